// >>> dv/tb_top.sv
// self-checking bench for the tuner configuration register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) check_eq(32'(g), 32'(e))
module tb_top;
  logic clk_in, rst_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in;
  logic s_axi_arvalid_in, s_axi_rready_in, ref_divider_pin_open_in;
  logic [7:0] s_axi_awaddr_in, s_axi_araddr_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
  logic [3:0] s_axi_wstrb_in;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
  logic s_axi_rvalid_out, ref_out_full_rate_out, vco_autoselect_enable_out;
  logic autoselect_from_current_out, autoselect_idle_flag_out, tune_adc_latch_out;
  logic tune_adc_read_enable_out, wideband_detector_on_out, narrowband_detector_on_out;
  logic detector_pullup_out, agc_diode_off_out;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, charge_pump_linearity_out;
  logic [1:0] osc_level_control_out, low_freq_clock_divider_out, autoselect_wait_time_out;
  logic [1:0] agc_diode_voltage_out;
  logic [2:0] wideband_attack_point_out, narrowband_attack_point_out;
  int n_mismatch = 0;
  int n_compared = 0;
  // device under test
  tscr_regs uut (.clk_in, .rst_in, .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out,
    .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out,
    .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in,
    .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out,
    .s_axi_rready_in, .ref_divider_pin_open_in, .ref_out_full_rate_out,
    .charge_pump_linearity_out, .osc_level_control_out, .low_freq_clock_divider_out,
    .vco_autoselect_enable_out, .autoselect_wait_time_out, .autoselect_from_current_out,
    .autoselect_idle_flag_out, .tune_adc_latch_out, .tune_adc_read_enable_out,
    .wideband_detector_on_out, .wideband_attack_point_out, .narrowband_detector_on_out,
    .narrowband_attack_point_out, .detector_pullup_out, .agc_diode_voltage_out,
    .agc_diode_off_out);
  // verdict and end of run
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // one comparison
  task automatic check_eq(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // a wait ran out
  task automatic timed_out();
    check_eq(32'h0, 32'h1);
    complete_run();
  endtask
  // bus write with expected response
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= {24'h0, d};
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    do
    begin
      @(posedge clk_in);
      n++;
      if (n > 50)
        timed_out();
      if (s_axi_awvalid_in && s_axi_awready_out)
        s_axi_awvalid_in <= 1'b0;
      if (s_axi_wvalid_in && s_axi_wready_out)
        s_axi_wvalid_in <= 1'b0;
    end while (s_axi_bvalid_out !== 1'b1);
    check_eq(s_axi_bresp_out, er);
    s_axi_bready_in <= 1'b0;
  endtask
  // bus read with expected byte and response
  task automatic axi_rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    do
    begin
      @(posedge clk_in);
      n++;
      if (n > 50)
        timed_out();
      if (s_axi_arvalid_in && s_axi_arready_out)
        s_axi_arvalid_in <= 1'b0;
    end while (s_axi_rvalid_out !== 1'b1);
    check_eq(s_axi_rdata_out, {24'h0, d});
    check_eq(s_axi_rresp_out, er);
    s_axi_rready_in <= 1'b0;
  endtask
  // reset values of every register
  task automatic t_reset();
    axi_rd(8'h10, tscr_pkg::RST_FRAC_LOW, 2'h0);
    axi_rd(8'h24, tscr_pkg::RST_REF_CFG, 2'h0);
    axi_rd(8'h28, tscr_pkg::RST_VAS_CFG, 2'h0);
    axi_rd(8'h2c, tscr_pkg::RST_PD_CFG1, 2'h0);
    axi_rd(8'h30, tscr_pkg::RST_PD_CFG2, 2'h0);
    axi_rd(8'h44, 8'h01, 2'h0);
    $display("test reset done");
  endtask
  // reference divider bit and pin
  task automatic t_ref();
    axi_wr(8'h24, 8'hff, 2'h0);
    #1;
    `CHK(ref_out_full_rate_out, 1'b1);
    `CHK({charge_pump_linearity_out, osc_level_control_out}, 4'hf);
    axi_rd(8'h24, 8'h1f, 2'h0);
    axi_wr(8'h24, 8'h0a, 2'h0);
    #1;
    `CHK(ref_out_full_rate_out, 1'b0);
    `CHK({charge_pump_linearity_out, osc_level_control_out}, 4'h5);
    axi_wr(8'h24, 8'h0b, 2'h0);
    @(posedge clk_in);
    ref_divider_pin_open_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    `CHK(ref_out_full_rate_out, 1'b0);
    $display("test reference done");
  endtask
  // autoselect configuration patterns and converter controls
  task automatic t_vas();
    logic [7:0] p [4] = '{8'h12, 8'h52, 8'h92, 8'hd2};
    foreach (p[i])
    begin
      axi_wr(8'h28, p[i], 2'h0);
      #1;
      `CHK({low_freq_clock_divider_out, vco_autoselect_enable_out}, {p[i][7:6], 1'b1});
      `CHK(autoselect_wait_time_out, 2'h2);
      `CHK({tune_adc_latch_out, tune_adc_read_enable_out}, 2'h0);
      axi_rd(8'h28, p[i], 2'h0);
    end
    axi_wr(8'h28, 8'h0c, 2'h0);
    #1;
    `CHK({vco_autoselect_enable_out, tune_adc_latch_out, tune_adc_read_enable_out}, 3'h3);
    axi_wr(8'h28, 8'h08, 2'h0);
    #1;
    `CHK({tune_adc_latch_out, tune_adc_read_enable_out}, 2'h2);
    $display("test autoselect config done");
  endtask
  // detector fields and diode codes
  task automatic t_pd();
    logic [7:0] p [4] = '{8'h43, 8'hcb, 8'h07, 8'hf8};
    foreach (p[i])
    begin
      axi_wr(8'h2c, p[i], 2'h0);
      #1;
      `CHK({wideband_detector_on_out, wideband_attack_point_out}, {~p[i][7], p[i][6:4]});
      `CHK({narrowband_detector_on_out, narrowband_attack_point_out}, {~p[i][3], p[i][2:0]});
    end
    for (int c = 0; c < 4; c++)
    begin
      axi_wr(8'h30, {6'h3f, 2'(c)}, 2'h0);
      #1;
      `CHK({detector_pullup_out, agc_diode_voltage_out, agc_diode_off_out}, {1'b1, 2'(c), c == 3});
      axi_rd(8'h30, {6'h01, 2'(c)}, 2'h0);
    end
    $display("test detector done");
  endtask
  // autoselect runs, start point, return to idle by reset
  task automatic t_run();
    time t0;
    int n;
    axi_wr(8'h28, 8'h32, 2'h0);
    axi_wr(8'h10, 8'h66, 2'h0);
    #1;
    t0 = $time;
    `CHK(autoselect_idle_flag_out, 1'b0);
    axi_rd(8'h44, 8'h00, 2'h0);
    // start point shows one edge after the run tracker latches it
    `CHK(autoselect_from_current_out, 1'b1);
    n = 0;
    while (autoselect_idle_flag_out !== 1'b1)
    begin
      @(posedge clk_in);
      #1;
      n++;
      if (n > 40)
        timed_out();
    end
    n = int'(($time - t0) / 40);
    `CHK(n + 1 >= tscr_pkg::RUN_CYCLES && n <= tscr_pkg::RUN_CYCLES + 3, 1'b1);
    axi_wr(8'h28, 8'h12, 2'h0);
    axi_wr(8'h10, 8'h66, 2'h0);
    #1;
    `CHK(autoselect_idle_flag_out, 1'b0);
    repeat (2) @(posedge clk_in);
    #1;
    `CHK(autoselect_from_current_out, 1'b0);
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    #1;
    `CHK(autoselect_idle_flag_out, 1'b1);
    $display("test autoselect run done");
  endtask
  // unmapped and read-only places
  task automatic t_decode();
    axi_wr(8'h3c, 8'h55, tscr_pkg::RESP_DECERR);
    axi_rd(8'h3c, 8'h00, tscr_pkg::RESP_DECERR);
    axi_wr(8'h44, 8'h00, 2'h0);
    axi_rd(8'h44, 8'h01, 2'h0);
    $display("test decode done");
  endtask
  // clock
  initial
  begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  // main sequence
  initial
  begin
    rst_in = 1'b1;
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = 3'h0;
    {s_axi_arvalid_in, s_axi_rready_in} = 2'h0;
    s_axi_awaddr_in = 8'h0;
    s_axi_araddr_in = 8'h0;
    s_axi_wdata_in = 32'h0;
    s_axi_wstrb_in = 4'h1;
    ref_divider_pin_open_in = 1'b1;
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_ref();
    t_vas();
    t_pd();
    t_run();
    t_decode();
    complete_run();
  end
endmodule
`default_nettype wire

// >>> dv/tscr_regs_monitor.sv
// port checker for the tuner configuration register bank
`timescale 1ns/1ps
`default_nettype none
module tscr_regs_monitor (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // register bus
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // decoded controls
  input wire logic ref_divider_pin_open_in,
  input wire logic ref_out_full_rate_out,
  input wire logic vco_autoselect_enable_out,
  input wire logic tune_adc_latch_out,
  input wire logic tune_adc_read_enable_out,
  input wire logic autoselect_idle_flag_out,
  input wire logic [1:0] agc_diode_voltage_out,
  input wire logic agc_diode_off_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // address and data taken together
  sequence s_wr_taken;
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
  endsequence
  // write to the lowest fraction register with lane 0 enabled
  sequence s_wr_frac;
    s_wr_taken ##0 (s_axi_awaddr_in == 8'h10) && s_axi_wstrb_in[0];
  endsequence
  // run stays active for a minimum stretch
  sequence s_run_busy;
    (!autoselect_idle_flag_out) [*8];
  endsequence
  property p_run_start;
    s_wr_frac |-> ##[1:2] !autoselect_idle_flag_out;
  endproperty
  a_run_start: assert property (p_run_start) else $error("run did not start");
  property p_run_len;
    $fell(autoselect_idle_flag_out) |-> s_run_busy ##[1:14] autoselect_idle_flag_out;
  endproperty
  a_run_len: assert property (p_run_len) else $error("run length wrong");
  property p_wr_resp;
    s_wr_taken |-> ##[1:2] s_axi_bvalid_out;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("no write response");
  property p_b_hold;
    s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold;
    s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_ar_block;
    s_axi_rvalid_out |-> !s_axi_arready_out;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
  property p_rd_upper;
    s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h0;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
  property p_adc_gate;
    vco_autoselect_enable_out |-> !tune_adc_latch_out && !tune_adc_read_enable_out;
  endproperty
  a_adc_gate: assert property (p_adc_gate) else $error("converter control not gated");
  property p_diode_off;
    agc_diode_off_out == (agc_diode_voltage_out == 2'h3);
  endproperty
  a_diode_off: assert property (p_diode_off) else $error("diode off decode wrong");
  property p_pin_closed;
    !ref_divider_pin_open_in && !$past(ref_divider_pin_open_in) |-> !ref_out_full_rate_out;
  endproperty
  a_pin_closed: assert property (p_pin_closed) else $error("full rate with pin tied");
endmodule
bind tscr_regs tscr_regs_monitor u_mon (.clk_in, .rst_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
  .s_axi_awready_out, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out,
  .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rvalid_out,
  .s_axi_rready_in, .ref_divider_pin_open_in, .ref_out_full_rate_out, .vco_autoselect_enable_out,
  .tune_adc_latch_out, .tune_adc_read_enable_out, .autoselect_idle_flag_out,
  .agc_diode_voltage_out, .agc_diode_off_out);
`default_nettype wire

// >>> hw/tscr_pkg.sv
// constants for the tuner synthesizer and detector configuration register bank
package tscr_pkg;
  // register indices; byte address on the bus is four times the index
  localparam logic [7:0] IDX_FRAC_LOW = 8'h04;
  localparam logic [7:0] IDX_REF_CFG = 8'h09;
  localparam logic [7:0] IDX_VAS_CFG = 8'h0a;
  localparam logic [7:0] IDX_PD_CFG1 = 8'h0b;
  localparam logic [7:0] IDX_PD_CFG2 = 8'h0c;
  localparam logic [7:0] IDX_VAS_STAT = 8'h11;
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_FRAC_LOW = 8'h10;
  localparam logic [7:0] ADDR_REF_CFG = 8'h24;
  localparam logic [7:0] ADDR_VAS_CFG = 8'h28;
  localparam logic [7:0] ADDR_PD_CFG1 = 8'h2c;
  localparam logic [7:0] ADDR_PD_CFG2 = 8'h30;
  localparam logic [7:0] ADDR_VAS_STAT = 8'h44;
  // reset values (typical settings)
  localparam logic [7:0] RST_FRAC_LOW = 8'h66;
  localparam logic [7:0] RST_REF_CFG = 8'h0a;
  localparam logic [7:0] RST_VAS_CFG = 8'h12;
  localparam logic [7:0] RST_PD_CFG1 = 8'h43;
  localparam logic [7:0] RST_PD_CFG2 = 8'h01;
  // writable bit masks; other bits ignore writes and read zero
  localparam logic [7:0] MASK_REF_CFG = 8'h1f;
  localparam logic [7:0] MASK_VAS_CFG = 8'hff;
  localparam logic [7:0] MASK_PD_CFG1 = 8'hff;
  localparam logic [7:0] MASK_PD_CFG2 = 8'h07;
  // field positions
  localparam int REF_DIV_BIT = 0;
  localparam int OSC_LVL_LSB = 1;
  localparam int CP_LIN_LSB = 3;
  localparam int WAIT_LSB = 0;
  localparam int ADC_READ_BIT = 2;
  localparam int ADC_LATCH_BIT = 3;
  localparam int VAS_EN_BIT = 4;
  localparam int START_SEL_BIT = 5;
  localparam int LF_DIV_LSB = 6;
  localparam int NB_ATT_LSB = 0;
  localparam int NB_DIS_BIT = 3;
  localparam int WB_ATT_LSB = 4;
  localparam int WB_DIS_BIT = 7;
  localparam int DIODE_LSB = 0;
  localparam int PULLUP_BIT = 2;
  localparam int IDLE_BIT = 0;
  localparam logic [1:0] DIODE_OFF = 2'h3;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // length of one autoselect run
  localparam int RUN_TIME_NS = 640;
  localparam int CLK_PERIOD_NS = 40;
  localparam int RUN_CYCLES = (RUN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] RUN_COUNT = 8'(RUN_CYCLES);
endpackage

// >>> hw/tscr_regs.sv
// tuner synthesizer and detector configuration registers on an axi4-lite slave
// Operation
// RULE_01 - divider bit picks reference output rate
// RULE_02 - software writes 01 to both fields
// RULE_03 - software picks divider code per band
// RULE_04 - start bit chooses search starting point
// RULE_05 - software keeps autoselect enabled
// RULE_06 - latch bit acts only without autoselect
// RULE_07 - read bit acts only without autoselect
// RULE_08 - software writes wait time 10
// RULE_09 - software uses only tested autoselect patterns
// RULE_10 - wideband disable bit switches detector
// RULE_11 - wideband attack point field, nominal 100
// RULE_12 - narrowband disable bit switches detector
// RULE_13 - narrowband attack point field, nominal 011
// RULE_14 - software uses only tested detector pattern
// RULE_15 - software keeps pull-up bit cleared
// RULE_16 - diode voltage field, code 11 off
// RULE_17 - low fraction write starts autoselect run
// RULE_18 - idle flag zero while run active
// RULE_19 - unused bits ignore writes, read zero
`timescale 1ns/1ps
`default_nettype none
module tscr_regs (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // reference divider pin state
  input wire logic ref_divider_pin_open_in,
  // reference oscillator controls
  output logic ref_out_full_rate_out,
  output logic [1:0] charge_pump_linearity_out,
  output logic [1:0] osc_level_control_out,
  // autoselect controls
  output logic [1:0] low_freq_clock_divider_out,
  output logic vco_autoselect_enable_out,
  output logic [1:0] autoselect_wait_time_out,
  output logic autoselect_from_current_out,
  output logic autoselect_idle_flag_out,
  output logic tune_adc_latch_out,
  output logic tune_adc_read_enable_out,
  // power detector and diode controls
  output logic wideband_detector_on_out,
  output logic [2:0] wideband_attack_point_out,
  output logic narrowband_detector_on_out,
  output logic [2:0] narrowband_attack_point_out,
  output logic detector_pullup_out,
  output logic [1:0] agc_diode_voltage_out,
  output logic agc_diode_off_out
);
  tscr_run_if run_link ();

  // bus handshake state
  logic aw_held_reg;
  logic aw_held_next;
  logic w_held_reg;
  logic w_held_next;
  logic [7:0] waddr_reg;
  logic [7:0] waddr_next;
  logic [7:0] wbyte_reg;
  logic [7:0] wbyte_next;
  logic wlane_reg;
  logic wlane_next;
  logic awready_reg;
  logic awready_next;
  logic wready_reg;
  logic wready_next;
  logic bvalid_reg;
  logic bvalid_next;
  logic [1:0] bresp_reg;
  logic [1:0] bresp_next;
  logic arready_reg;
  logic arready_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [1:0] rresp_reg;
  logic [1:0] rresp_next;
  logic do_write;
  logic [7:0] rd_byte;
  logic rd_hit;

  // register contents
  logic [7:0] frac_low_reg;
  logic [7:0] frac_low_next;
  logic [7:0] ref_cfg_reg;
  logic [7:0] ref_cfg_next;
  logic [7:0] vas_cfg_reg;
  logic [7:0] vas_cfg_next;
  logic [7:0] pd_cfg1_reg;
  logic [7:0] pd_cfg1_next;
  logic [7:0] pd_cfg2_reg;
  logic [7:0] pd_cfg2_next;
  logic start_reg;
  logic start_next;
  logic idle_reg;
  logic idle_next;

  // decoded outputs
  logic [18:0] out_reg;
  logic [18:0] out_next;
  logic [1:0] diode_code;

  // read mux over the mapped words
  always_comb
  begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    case ({s_axi_araddr_in[7:2], 2'b00})
      tscr_pkg::ADDR_FRAC_LOW: rd_byte = frac_low_reg;
      tscr_pkg::ADDR_REF_CFG: rd_byte = ref_cfg_reg & tscr_pkg::MASK_REF_CFG; // RULE_19
      tscr_pkg::ADDR_VAS_CFG: rd_byte = vas_cfg_reg;
      tscr_pkg::ADDR_PD_CFG1: rd_byte = pd_cfg1_reg;
      tscr_pkg::ADDR_PD_CFG2: rd_byte = pd_cfg2_reg & tscr_pkg::MASK_PD_CFG2; // RULE_19
      tscr_pkg::ADDR_VAS_STAT: rd_byte = {7'h00, idle_reg}; // RULE_18
      default: rd_hit = 1'b0;
    endcase
  end

  // bus channels: address and data taken in either order, then one response
  always_comb
  begin
    aw_held_next = aw_held_reg;
    w_held_next = w_held_reg;
    waddr_next = waddr_reg;
    wbyte_next = wbyte_reg;
    wlane_next = wlane_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    do_write = aw_held_reg && w_held_reg && !bvalid_reg;
    if (s_axi_awvalid_in && awready_reg)
    begin
      aw_held_next = 1'b1;
      waddr_next = {s_axi_awaddr_in[7:2], 2'b00};
    end
    if (s_axi_wvalid_in && wready_reg)
    begin
      w_held_next = 1'b1;
      wbyte_next = s_axi_wdata_in[7:0];
      wlane_next = s_axi_wstrb_in[0];
    end
    if (do_write)
    begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = tscr_pkg::RESP_DECERR;
      case (waddr_reg)
        tscr_pkg::ADDR_FRAC_LOW, tscr_pkg::ADDR_REF_CFG, tscr_pkg::ADDR_VAS_CFG,
        tscr_pkg::ADDR_PD_CFG1, tscr_pkg::ADDR_PD_CFG2,
        tscr_pkg::ADDR_VAS_STAT: bresp_next = tscr_pkg::RESP_OKAY;
        default: bresp_next = tscr_pkg::RESP_DECERR;
      endcase
    end
    else if (bvalid_reg && s_axi_bready_in)
    begin
      bvalid_next = 1'b0;
    end
    if (s_axi_arvalid_in && arready_reg)
    begin
      rvalid_next = 1'b1;
      rdata_next = {24'h000000, rd_byte};
      rresp_next = rd_hit ? tscr_pkg::RESP_OKAY : tscr_pkg::RESP_DECERR;
    end
    else if (rvalid_reg && s_axi_rready_in)
    begin
      rvalid_next = 1'b0;
    end
    awready_next = !aw_held_next && !bvalid_next;
    wready_next = !w_held_next && !bvalid_next;
    arready_next = !rvalid_next;
  end

  // bus state registers
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      waddr_reg <= 8'h00;
      wbyte_reg <= 8'h00;
      wlane_reg <= 1'b0;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= 2'h0;
    end
    else
    begin
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      waddr_reg <= waddr_next;
      wbyte_reg <= wbyte_next;
      wlane_reg <= wlane_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  // register writes; only byte lane 0 carries data
  always_comb
  begin
    frac_low_next = frac_low_reg;
    ref_cfg_next = ref_cfg_reg;
    vas_cfg_next = vas_cfg_reg;
    pd_cfg1_next = pd_cfg1_reg;
    pd_cfg2_next = pd_cfg2_reg;
    start_next = 1'b0;
    if (do_write && wlane_reg)
    begin
      case (waddr_reg)
        tscr_pkg::ADDR_FRAC_LOW:
        begin
          frac_low_next = wbyte_reg;
          start_next = 1'b1; // RULE_17
        end
        tscr_pkg::ADDR_REF_CFG: ref_cfg_next = wbyte_reg & tscr_pkg::MASK_REF_CFG; // RULE_19
        tscr_pkg::ADDR_VAS_CFG: vas_cfg_next = wbyte_reg & tscr_pkg::MASK_VAS_CFG;
        tscr_pkg::ADDR_PD_CFG1: pd_cfg1_next = wbyte_reg & tscr_pkg::MASK_PD_CFG1;
        tscr_pkg::ADDR_PD_CFG2: pd_cfg2_next = wbyte_reg & tscr_pkg::MASK_PD_CFG2; // RULE_19
        default: start_next = 1'b0;
      endcase
    end
    // flag drops in the very cycle the run is requested
    idle_next = !(start_next || start_reg || run_link.busy); // RULE_18
  end

  // register contents and run request
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      frac_low_reg <= tscr_pkg::RST_FRAC_LOW;
      ref_cfg_reg <= tscr_pkg::RST_REF_CFG;
      vas_cfg_reg <= tscr_pkg::RST_VAS_CFG;
      pd_cfg1_reg <= tscr_pkg::RST_PD_CFG1;
      pd_cfg2_reg <= tscr_pkg::RST_PD_CFG2;
      start_reg <= 1'b0;
      idle_reg <= 1'b1;
    end
    else
    begin
      frac_low_reg <= frac_low_next;
      ref_cfg_reg <= ref_cfg_next;
      vas_cfg_reg <= vas_cfg_next;
      pd_cfg1_reg <= pd_cfg1_next;
      pd_cfg2_reg <= pd_cfg2_next;
      start_reg <= start_next;
      idle_reg <= idle_next;
    end
  end

  // run request carries the start-point choice at the time of the write
  assign run_link.start = start_reg;
  assign run_link.start_sel = vas_cfg_reg[tscr_pkg::START_SEL_BIT]; // RULE_04

  tscr_run run_tracker (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .run_if(run_link)
  );

  // decode fields into registered control outputs
  always_comb
  begin
    diode_code = pd_cfg2_next[tscr_pkg::DIODE_LSB +: 2];
    out_next[0] = ref_divider_pin_open_in && ref_cfg_next[tscr_pkg::REF_DIV_BIT]; // RULE_01
    out_next[2:1] = ref_cfg_next[tscr_pkg::CP_LIN_LSB +: 2];
    out_next[4:3] = ref_cfg_next[tscr_pkg::OSC_LVL_LSB +: 2];
    out_next[6:5] = vas_cfg_next[tscr_pkg::LF_DIV_LSB +: 2];
    out_next[7] = vas_cfg_next[tscr_pkg::VAS_EN_BIT];
    out_next[9:8] = vas_cfg_next[tscr_pkg::WAIT_LSB +: 2];
    // converter controls only take effect with autoselect off
    out_next[10] = !vas_cfg_next[tscr_pkg::VAS_EN_BIT]
      && vas_cfg_next[tscr_pkg::ADC_LATCH_BIT]; // RULE_06
    out_next[11] = !vas_cfg_next[tscr_pkg::VAS_EN_BIT]
      && vas_cfg_next[tscr_pkg::ADC_READ_BIT]; // RULE_07
    out_next[12] = !pd_cfg1_next[tscr_pkg::WB_DIS_BIT]; // RULE_10
    out_next[15:13] = pd_cfg1_next[tscr_pkg::WB_ATT_LSB +: 3]; // RULE_11
    out_next[16] = !pd_cfg1_next[tscr_pkg::NB_DIS_BIT]; // RULE_12
    out_next[18:17] = diode_code; // RULE_16
  end

  // output registers
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      out_reg <= 19'h00000;
      narrowband_attack_point_out <= 3'h0;
      detector_pullup_out <= 1'b0;
      agc_diode_off_out <= 1'b0;
      autoselect_from_current_out <= 1'b0;
    end
    else
    begin
      out_reg <= out_next;
      narrowband_attack_point_out <= pd_cfg1_next[tscr_pkg::NB_ATT_LSB +: 3]; // RULE_13
      detector_pullup_out <= pd_cfg2_next[tscr_pkg::PULLUP_BIT];
      agc_diode_off_out <= (diode_code == tscr_pkg::DIODE_OFF); // RULE_16
      autoselect_from_current_out <= run_link.from_current; // RULE_04
    end
  end

  // port wiring from registers
  assign s_axi_awready_out = awready_reg;
  assign s_axi_wready_out = wready_reg;
  assign s_axi_bvalid_out = bvalid_reg;
  assign s_axi_bresp_out = bresp_reg;
  assign s_axi_arready_out = arready_reg;
  assign s_axi_rvalid_out = rvalid_reg;
  assign s_axi_rdata_out = rdata_reg;
  assign s_axi_rresp_out = rresp_reg;
  assign autoselect_idle_flag_out = idle_reg;
  assign ref_out_full_rate_out = out_reg[0];
  assign charge_pump_linearity_out = out_reg[2:1];
  assign osc_level_control_out = out_reg[4:3];
  assign low_freq_clock_divider_out = out_reg[6:5];
  assign vco_autoselect_enable_out = out_reg[7];
  assign autoselect_wait_time_out = out_reg[9:8];
  assign tune_adc_latch_out = out_reg[10];
  assign tune_adc_read_enable_out = out_reg[11];
  assign wideband_detector_on_out = out_reg[12];
  assign wideband_attack_point_out = out_reg[15:13];
  assign narrowband_detector_on_out = out_reg[16];
  assign agc_diode_voltage_out = out_reg[18:17];
endmodule
`default_nettype wire

// >>> hw/tscr_run.sv
// autoselect run tracker: busy for a fixed time after each start
`timescale 1ns/1ps
`default_nettype none
module tscr_run (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // link to register bank
  tscr_run_if.run run_if
);
  logic busy_reg;
  logic busy_next;
  logic from_current_reg;
  logic from_current_next;
  logic [7:0] count_reg;
  logic [7:0] count_next;

  // a start (re)arms the run and latches where the search begins
  always_comb
  begin
    busy_next = busy_reg;
    from_current_next = from_current_reg;
    count_next = count_reg;
    if (run_if.start)
    begin
      busy_next = 1'b1; // RULE_17
      from_current_next = run_if.start_sel; // RULE_04
      count_next = tscr_pkg::RUN_COUNT;
    end
    else if (busy_reg)
    begin
      count_next = count_reg - 8'h01;
      if (count_reg == 8'h01)
      begin
        busy_next = 1'b0;
      end
    end
  end

  // state registers
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      busy_reg <= 1'b0;
      from_current_reg <= 1'b0;
      count_reg <= 8'h00;
    end
    else
    begin
      busy_reg <= busy_next;
      from_current_reg <= from_current_next;
      count_reg <= count_next;
    end
  end

  assign run_if.busy = busy_reg;
  assign run_if.from_current = from_current_reg;
endmodule
`default_nettype wire

// >>> hw/tscr_run_if.sv
// link between the register bank and the autoselect run tracker
`timescale 1ns/1ps
`default_nettype none
interface tscr_run_if;
  logic start;
  logic start_sel;
  logic busy;
  logic from_current;
  modport ctrl (output start, output start_sel, input busy, input from_current);
  modport run (input start, input start_sel, output busy, output from_current);
endinterface
`default_nettype wire
